// ===== core/tsa_pkg.sv
// Register map, reset values and field positions of the thermal shutdown and alert mask block
package tsa_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_SCRATCH_A = 8'h11;
  localparam logic [7:0] OFS_SCRATCH_B = 8'h12;
  localparam logic [7:0] OFS_EXT1_LIMIT = 8'h19;
  localparam logic [7:0] OFS_EXT2_LIMIT = 8'h1A;
  localparam logic [7:0] OFS_FAULT_FLAGS = 8'h1B;
  localparam logic [7:0] OFS_LINK_CFG = 8'h1D;
  localparam logic [7:0] OFS_HW_LIMIT = 8'h1E;
  localparam logic [7:0] OFS_ALERT_MASK = 8'h1F;
  localparam logic [7:0] OFS_INT_LIMIT = 8'h20;
  localparam logic [7:0] OFS_HYST = 8'h21;
  localparam logic [7:0] OFS_EXT3_LIMIT = 8'h30;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h41;
  localparam logic [7:0] OFS_RANGE_CFG = 8'h42;
  localparam logic [7:0] OFS_CRIT_STATUS = 8'h43;

  // ----------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0A;
  localparam logic [7:0] HW_HYST = 8'h0A;
  localparam logic [7:0] RANGE_OFFSET = 8'h40;
  localparam logic [7:0] RANGE_TOP = 8'hBF;
  localparam logic [7:0] CODE_MAX = 8'hFF;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int NUM_CH = 4;
  localparam int CH_INT = 0;
  localparam int CH_EXT1 = 1;
  localparam int CH_EXT2 = 2;
  localparam int CH_EXT3 = 3;
  localparam int RANGE_BIT = 0;
  localparam int IRQ_CRIT_LSB = 0;
  localparam int IRQ_FAULT_LSB = 4;
  localparam int IRQ_W = 7;
endpackage

// ===== core/tsa_trip.sv
// Over-limit detector with hysteresis release for one temperature channel
`timescale 1ns/1ns
module tsa_trip
  import tsa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] temp,
  input wire logic [7:0] limit,
  input wire logic [7:0] hyst,
  output logic trip
);
  typedef struct packed
  {
    logic trip;
  } tsa_trip_s;

  tsa_trip_s s_q;
  tsa_trip_s s_d;
  logic below;

  // Nine bits so that limit minus hysteresis never wraps below zero
  assign below = ({1'b0, temp} + {1'b0, hyst}) < {1'b0, limit};

  always_comb
  begin
    s_d = s_q;
    if (temp > limit)
    begin
      s_d.trip = 1'b1;
    end
    else if (below)
    begin
      s_d.trip = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign trip = s_q.trip;
endmodule

// ===== core/tsa_core.sv
// Critical temperature shutdown, diode fault flags, alert masking and scratchpad registers
`timescale 1ns/1ns
// Overview of operation
// - Two 8-bit scratch registers, reset zero, read back last written value.
// - One critical limit per channel, each resetting to 85 degrees.
// - Critical status bit set when reading strictly exceeds limit, linked or not.
// - Link register bits 3..0 let ext3, ext2, ext1, internal drive shutdown.
// - Linked shutdown holds until reading drops below limit minus shared hysteresis.
// - Shutdown asserts from linked channels or hardware limit, either alone.
// - Fault flags bits 3..1 record which external diode reported a fault.
// - Reading the fault flag register returns it, then clears every flag whose diode reports no fault in that cycle.
// - Read-only hardware limit comes from straps, encoded in selected range format.
// - External 1 above hardware limit asserts shutdown, releases below limit minus 10 degrees.
// - Mask register bits 3..0 stop the matching channel from asserting alert.
// - Masked external channel raises no alert for out-of-limit or diode fault.
// - Mask bits never affect the shutdown output.
// - Internal mask bit only covers internal out-of-limit; internal has no fault.
// - Range bit clear selects plain binary, set selects offset binary from -64.
// - Shutdown output is active low.
module tsa_core
  import tsa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] temp_int,
  input wire logic [7:0] temp_ext1,
  input wire logic [7:0] temp_ext2,
  input wire logic [7:0] temp_ext3,
  input wire logic [3:0] out_of_limit,
  input wire logic [3:1] diode_fault_in,
  input wire logic [7:0] hw_limit_strap,
  output logic system_shutdown_out_n,
  output logic alert_out_n,
  output logic irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    logic [7:0] scr_a;
    logic [7:0] scr_b;
    logic [NUM_CH-1:0][7:0] lim;
    logic [7:0] hyst;
    logic [3:0] link;
    logic [3:0] amask;
    logic [3:1] flt;
    logic range;
    logic [7:0] strap;
    logic strap_ok;
    logic [3:0] crit_prev;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] imask;
    logic alert_n;
    logic shdn_n;
    logic [7:0] rdata;
  } tsa_state_s;

  tsa_state_s s_q;
  tsa_state_s s_d;
  logic [NUM_CH-1:0][7:0] temps;
  logic [NUM_CH-1:0] trip;
  logic [NUM_CH-1:0] crit_now;
  logic hw_trip;
  logic [7:0] hw_limit;

  localparam tsa_state_s RST_STATE = '{
    scr_a: RST_ZERO,
    scr_b: RST_ZERO,
    lim: {RST_LIMIT, RST_LIMIT, RST_LIMIT, RST_LIMIT},
    hyst: RST_HYST,
    link: 4'h0,
    amask: 4'h0,
    flt: 3'h0,
    range: 1'b0,
    strap: RST_ZERO,
    strap_ok: 1'b0,
    crit_prev: 4'h0,
    ists: 7'h00,
    imask: 7'h00,
    alert_n: 1'b1,
    shdn_n: 1'b1,
    rdata: RST_ZERO
  };

  // Strap value in degrees, re-encoded in the active format
  function automatic logic [7:0] enc_hw(input logic [7:0] deg, input logic rng);
    logic [7:0] r;
    r = deg;
    if (rng)
    begin
      r = (deg > RANGE_TOP) ? CODE_MAX : 8'(deg + RANGE_OFFSET);
    end
    return r;
  endfunction

  function automatic logic [7:0] rd_mux(input tsa_state_s s, input logic [7:0] a,
                                        input logic [7:0] hw, input logic [3:0] cs);
    logic [7:0] r;
    r = RST_ZERO;
    if (a == OFS_SCRATCH_A)
    begin
      r = s.scr_a;
    end
    else if (a == OFS_SCRATCH_B)
    begin
      r = s.scr_b;
    end
    else if (a == OFS_EXT1_LIMIT)
    begin
      r = s.lim[CH_EXT1];
    end
    else if (a == OFS_EXT2_LIMIT)
    begin
      r = s.lim[CH_EXT2];
    end
    else if (a == OFS_EXT3_LIMIT)
    begin
      r = s.lim[CH_EXT3];
    end
    else if (a == OFS_INT_LIMIT)
    begin
      r = s.lim[CH_INT];
    end
    else if (a == OFS_FAULT_FLAGS)
    begin
      r = {4'h0, s.flt, 1'b0};
    end
    else if (a == OFS_LINK_CFG)
    begin
      r = {4'h0, s.link};
    end
    else if (a == OFS_HW_LIMIT)
    begin
      r = hw;
    end
    else if (a == OFS_ALERT_MASK)
    begin
      r = {4'h0, s.amask};
    end
    else if (a == OFS_HYST)
    begin
      r = s.hyst;
    end
    else if (a == OFS_IRQ_STATUS)
    begin
      r = {1'b0, s.ists};
    end
    else if (a == OFS_IRQ_MASK)
    begin
      r = {1'b0, s.imask};
    end
    else if (a == OFS_RANGE_CFG)
    begin
      r = {7'h00, s.range};
    end
    else if (a == OFS_CRIT_STATUS)
    begin
      r = {4'h0, cs};
    end
    return r;
  endfunction

  // ----------------------------------------
  // Limit comparison
  // ----------------------------------------
  assign temps = {temp_ext3, temp_ext2, temp_ext1, temp_int};
  assign hw_limit = enc_hw(s_q.strap, s_q.range);

  // Unsigned compare serves both formats, provided limits follow the same format
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
      assign crit_now[c] = temps[c] > s_q.lim[c];
      tsa_trip u_trip (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .temp(temps[c]),
        .limit(s_q.lim[c]),
        .hyst(s_q.hyst),
        .trip(trip[c])
      );
    end
  endgenerate

  // Hardware limit uses a fixed hysteresis; inactive until the straps are caught
  tsa_trip u_hw_trip (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .temp(s_q.strap_ok ? temp_ext1 : RST_ZERO),
    .limit(hw_limit),
    .hyst(HW_HYST),
    .trip(hw_trip)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Straps are caught once after reset release
    if (!s_q.strap_ok)
    begin
      s_d.strap = hw_limit_strap;
      s_d.strap_ok = 1'b1;
    end
    if (reg_wr)
    begin
      if (reg_addr == OFS_SCRATCH_A)
      begin
        s_d.scr_a = reg_wdata;
      end
      else if (reg_addr == OFS_SCRATCH_B)
      begin
        s_d.scr_b = reg_wdata;
      end
      else if (reg_addr == OFS_EXT1_LIMIT)
      begin
        s_d.lim[CH_EXT1] = reg_wdata;
      end
      else if (reg_addr == OFS_EXT2_LIMIT)
      begin
        s_d.lim[CH_EXT2] = reg_wdata;
      end
      else if (reg_addr == OFS_EXT3_LIMIT)
      begin
        s_d.lim[CH_EXT3] = reg_wdata;
      end
      else if (reg_addr == OFS_INT_LIMIT)
      begin
        s_d.lim[CH_INT] = reg_wdata;
      end
      else if (reg_addr == OFS_LINK_CFG)
      begin
        s_d.link = reg_wdata[3:0];
      end
      else if (reg_addr == OFS_ALERT_MASK)
      begin
        s_d.amask = reg_wdata[3:0];
      end
      else if (reg_addr == OFS_HYST)
      begin
        s_d.hyst = reg_wdata;
      end
      else if (reg_addr == OFS_IRQ_STATUS)
      begin
        s_d.ists = s_q.ists & ~reg_wdata[IRQ_W-1:0];
      end
      else if (reg_addr == OFS_IRQ_MASK)
      begin
        s_d.imask = reg_wdata[IRQ_W-1:0];
      end
      else if (reg_addr == OFS_RANGE_CFG)
      begin
        s_d.range = reg_wdata[RANGE_BIT];
      end
      // Hardware limit offset takes no write path at all
    end
    if (reg_rd && reg_addr == OFS_FAULT_FLAGS)
    begin
      s_d.flt = 3'h0;
    end
    // A fault in the clearing cycle survives the read
    s_d.flt = s_d.flt | diode_fault_in;
    // Events set after the clear so that set wins
    s_d.ists[IRQ_CRIT_LSB +: NUM_CH] = s_d.ists[IRQ_CRIT_LSB +: NUM_CH] | (crit_now & ~s_q.crit_prev);
    s_d.ists[IRQ_FAULT_LSB +: 3] = s_d.ists[IRQ_FAULT_LSB +: 3] | diode_fault_in;
    s_d.crit_prev = crit_now;
    // Internal channel has no fault source, so its bit only gates out-of-limit
    s_d.alert_n = ~|(~s_q.amask & (out_of_limit | {s_q.flt, 1'b0}));
    // Mask bits take no part here
    s_d.shdn_n = ~(|(s_q.link & trip) | hw_trip);
    s_d.rdata = reg_rd ? rd_mux(s_q, reg_addr, hw_limit, crit_now) : RST_ZERO;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= RST_STATE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign system_shutdown_out_n = s_q.shdn_n;
  assign alert_out_n = s_q.alert_n;
  assign irq = |(s_q.ists & ~s_q.imask);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_scratch;
    reg_wr && reg_addr == OFS_SCRATCH_A ##1 reg_rd && reg_addr == OFS_SCRATCH_A
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");

  property p_limit;
    reg_wr && reg_addr == OFS_INT_LIMIT |=> s_q.lim[CH_INT] == $past(reg_wdata);
  endproperty
  a_limit: assert property (p_limit) else $error("limit not written");

  property p_crit;
    reg_rd && reg_addr == OFS_CRIT_STATUS |=> reg_rdata[CH_EXT1] == $past(temp_ext1 > s_q.lim[CH_EXT1]);
  endproperty
  a_crit: assert property (p_crit) else $error("critical status wrong");

  property p_link;
    |(s_q.link & trip) |=> !system_shutdown_out_n;
  endproperty
  a_link: assert property (p_link) else $error("linked shutdown missing");

  property p_hold;
    trip[CH_INT] && ({1'b0, temp_int} + {1'b0, s_q.hyst}) >= {1'b0, s_q.lim[CH_INT]} |=> trip[CH_INT];
  endproperty
  a_hold: assert property (p_hold) else $error("released inside hysteresis");

  property p_hw;
    hw_trip |=> !system_shutdown_out_n;
  endproperty
  a_hw: assert property (p_hw) else $error("hardware shutdown missing");

  property p_flt_set;
    diode_fault_in[CH_EXT2] |=> s_q.flt[CH_EXT2];
  endproperty
  a_flt_set: assert property (p_flt_set) else $error("fault flag not set");

  property p_flt_clr;
    reg_rd && reg_addr == OFS_FAULT_FLAGS && diode_fault_in == 3'h0
      |=> s_q.flt == 3'h0 && reg_rdata[3:1] == $past(s_q.flt);
  endproperty
  a_flt_clr: assert property (p_flt_clr) else $error("fault flags not cleared on read");

  property p_mask;
    (s_q.amask == 4'hF) [*2] |-> alert_out_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alert asserted");

  property p_no_shdn;
    !(|(s_q.link & trip)) && !hw_trip |=> system_shutdown_out_n;
  endproperty
  a_no_shdn: assert property (p_no_shdn) else $error("shutdown without cause");

  property p_hw_ro;
    reg_wr && reg_addr == OFS_HW_LIMIT && s_q.strap_ok |=> $stable(s_q.strap) && $stable(s_q.range);
  endproperty
  a_hw_ro: assert property (p_hw_ro) else $error("hardware limit changed by write");
endmodule

// ===== sim/tsa_pwr_ctl.sv
// Behavioural power controller that cuts the supply while the shutdown line is low
`timescale 1ns/1ns
module tsa_pwr_ctl
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic shdn_n,
  output logic powered,
  output logic [7:0] shdn_events
);
  logic shdn_q;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shdn_q <= 1'b0;
      powered <= 1'b1;
      shdn_events <= 8'h00;
    end
    else
    begin
      // Low means shut down; count each new request once
      shdn_q <= !shdn_n;
      powered <= shdn_n;
      if (!shdn_n && !shdn_q)
        shdn_events <= shdn_events + 8'h01;
    end
  end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the thermal shutdown and alert mask block
`timescale 1ns/1ns
module tb_top
  import tsa_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] temp_int = 8'h00;
  logic [7:0] temp_ext1 = 8'h00;
  logic [7:0] temp_ext2 = 8'h00;
  logic [7:0] temp_ext3 = 8'h00;
  logic [3:0] out_of_limit = 4'h0;
  logic [3:1] diode_fault_in = 3'h0;
  logic [7:0] hw_limit_strap = 8'h64;
  logic system_shutdown_out_n;
  logic alert_out_n;
  logic irq;
  logic powered;
  logic [7:0] shdn_events;
  int err_total = 0;
  int samples_checked = 0;

  always #50 sys_clk = ~sys_clk;

  tsa_core i_tsa_core (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_int(temp_int), .temp_ext1(temp_ext1),
    .temp_ext2(temp_ext2), .temp_ext3(temp_ext3), .out_of_limit(out_of_limit),
    .diode_fault_in(diode_fault_in), .hw_limit_strap(hw_limit_strap),
    .system_shutdown_out_n(system_shutdown_out_n), .alert_out_n(alert_out_n), .irq(irq));

  tsa_pwr_ctl i_tsa_pwr_ctl (.sys_clk(sys_clk), .nrst(nrst), .shdn_n(system_shutdown_out_n),
    .powered(powered), .shdn_events(shdn_events));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data live only in the cycle after the strobe edge
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Write then read the same register with no idle cycle between the strobes
  task automatic wr_rc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic shdn_is(input logic v);
    tick(3);
    chk({7'h00, system_shutdown_out_n}, {7'h00, v});
  endtask

  task automatic alert_is(input logic v);
    tick(3);
    chk({7'h00, alert_out_n}, {7'h00, v});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rc(OFS_SCRATCH_A, RST_ZERO);
    rc(OFS_SCRATCH_B, RST_ZERO);
    rc(OFS_EXT1_LIMIT, RST_LIMIT);
    rc(OFS_EXT2_LIMIT, RST_LIMIT);
    rc(OFS_EXT3_LIMIT, RST_LIMIT);
    rc(OFS_INT_LIMIT, RST_LIMIT);
    rc(OFS_HYST, RST_HYST);
    rc(OFS_LINK_CFG, RST_ZERO);
    rc(OFS_ALERT_MASK, RST_ZERO);
    rc(OFS_FAULT_FLAGS, RST_ZERO);
    rc(OFS_HW_LIMIT, 8'h64);
    wr(OFS_SCRATCH_A, 8'hA5);
    wr(OFS_SCRATCH_B, 8'h5A);
    wr(OFS_HW_LIMIT, 8'h00);
    wr(8'h7F, 8'hFF);
    rc(OFS_SCRATCH_A, 8'hA5);
    rc(OFS_SCRATCH_B, 8'h5A);
    wr_rc(OFS_SCRATCH_A, 8'h3C, 8'h3C);
    rc(OFS_HW_LIMIT, 8'h64);
    rc(8'h7F, 8'h00);
    // Equal to the limit is not over it
    @(posedge sys_clk);
    temp_int <= 8'h55;
    tick(3);
    rc(OFS_CRIT_STATUS, 8'h00);
    @(posedge sys_clk);
    temp_int <= 8'h56;
    tick(3);
    rc(OFS_CRIT_STATUS, 8'h01);
    shdn_is(1'b1);
    wr(OFS_LINK_CFG, 8'h01);
    shdn_is(1'b0);
    wr(OFS_ALERT_MASK, 8'h0F);
    shdn_is(1'b0);
    @(posedge sys_clk);
    temp_int <= 8'h4B;
    shdn_is(1'b0);
    @(posedge sys_clk);
    temp_int <= 8'h4A;
    shdn_is(1'b1);
    wr(OFS_LINK_CFG, 8'h00);
    // Hardware limit alone, ext1 unlinked
    @(posedge sys_clk);
    temp_ext1 <= 8'h65;
    shdn_is(1'b0);
    chk({7'h00, powered}, 8'h00);
    @(posedge sys_clk);
    temp_ext1 <= 8'h5A;
    shdn_is(1'b0);
    @(posedge sys_clk);
    temp_ext1 <= 8'h59;
    shdn_is(1'b1);
    chk(shdn_events, 8'h02);
    @(posedge sys_clk);
    temp_ext1 <= 8'h00;
    wr(OFS_RANGE_CFG, 8'h01);
    rc(OFS_HW_LIMIT, 8'hA4);
    // Extended range: limit and reading both in offset code, 85 degrees is 95h
    wr(OFS_INT_LIMIT, 8'h95);
    @(posedge sys_clk);
    temp_int <= 8'h95;
    tick(3);
    rc(OFS_CRIT_STATUS, 8'h00);
    @(posedge sys_clk);
    temp_int <= 8'h96;
    tick(3);
    rc(OFS_CRIT_STATUS, 8'h01);
    @(posedge sys_clk);
    temp_int <= 8'h00;
    wr(OFS_INT_LIMIT, RST_LIMIT);
    wr(OFS_RANGE_CFG, 8'h00);
    wr(OFS_ALERT_MASK, 8'h00);
    // Fault flags and alert masking
    @(posedge sys_clk);
    diode_fault_in <= 3'b010;
    @(posedge sys_clk);
    diode_fault_in <= 3'b000;
    alert_is(1'b0);
    rc(OFS_FAULT_FLAGS, 8'h04);
    rc(OFS_FAULT_FLAGS, 8'h00);
    alert_is(1'b1);
    wr(OFS_ALERT_MASK, 8'h08);
    @(posedge sys_clk);
    diode_fault_in <= 3'b100;
    @(posedge sys_clk);
    diode_fault_in <= 3'b000;
    alert_is(1'b1);
    rc(OFS_FAULT_FLAGS, 8'h08);
    wr(OFS_ALERT_MASK, 8'h02);
    @(posedge sys_clk);
    out_of_limit <= 4'h2;
    alert_is(1'b1);
    wr(OFS_ALERT_MASK, 8'h00);
    alert_is(1'b0);
    wr(OFS_ALERT_MASK, 8'h01);
    @(posedge sys_clk);
    out_of_limit <= 4'h1;
    alert_is(1'b1);
    wr(OFS_ALERT_MASK, 8'h00);
    alert_is(1'b0);
    @(posedge sys_clk);
    out_of_limit <= 4'h0;
    // Sticky events: int and ext1 over limit, ext2 and ext3 faults
    rc(OFS_IRQ_STATUS, 8'h63);
    wr(OFS_IRQ_MASK, 8'h7F);
    tick(1);
    chk({7'h00, irq}, 8'h00);
    wr(OFS_IRQ_MASK, 8'h00);
    tick(1);
    chk({7'h00, irq}, 8'h01);
    wr(OFS_IRQ_STATUS, 8'h7F);
    tick(1);
    chk({7'h00, irq}, 8'h00);
    rc(OFS_IRQ_STATUS, 8'h00);
    end_sim;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_sim;
  end
endmodule
